// file: rtl/tpc_pkg.sv
package tpc_pkg;

   // register byte offsets on the apb
   localparam logic [7:0] OFS_CMP_CTRL  = 8'h00;
   localparam logic [7:0] OFS_CMP_REF   = 8'h04;
   localparam logic [7:0] OFS_TMR_CTRL  = 8'h08;
   localparam logic [7:0] OFS_TMR_SCALE = 8'h0c;
   localparam logic [7:0] OFS_TMR_COUNT = 8'h10;
   localparam logic [7:0] OFS_TMR_BOUND = 8'h14;
   localparam logic [7:0] OFS_OPTION    = 8'h18;
   localparam logic [7:0] OFS_STATUS    = 8'h1c;

   // comparator_control fields
   localparam int CC_EN = 7;       // comparator enable
   localparam int CC_RES = 6;      // result, read only
   localparam int CC_SAMPLE = 5;   // sample result on counting clock
   localparam int CC_INV = 4;      // invert result
   localparam int CC_NEG_LO = 1;   // negative input select [3:1]
   localparam int CC_POS = 0;      // positive input select

   // comparator_reference_select fields
   localparam int RS_OUT = 7;      // result to port_pin_0
   localparam int RS_SPAN_LO = 4;  // ladder span [5:4]
   localparam int RS_LVL_LO = 0;   // ladder level [3:0]

   // timer_control fields
   localparam int TC_CLK_LO = 4;   // clock source [7:4]
   localparam int TC_OUT_LO = 2;   // output route [3:2]
   localparam int TC_MODE = 1;     // 0 period, 1 pwm
   localparam int TC_INV = 0;      // invert output

   // timer_scaling fields
   localparam int TS_RES6 = 7;     // pwm 6-bit (or 7-bit) resolution
   localparam int TS_PRE_LO = 5;   // prescale [6:5]
   localparam int TS_SCL_LO = 0;   // scaler [4:0]

   // option and status bits
   localparam int OP_GATE = 0;     // comparator_gates_pwm_option
   localparam int OP_RES7 = 1;     // 7-bit instead of 6-bit
   localparam int ST_CMP = 0;      // comparator result
   localparam int ST_WAVE = 1;     // timer waveform

   // clock source codes
   localparam logic [3:0] CS_SYS  = 4'h1;
   localparam logic [3:0] CS_HRC  = 4'h2;
   localparam logic [3:0] CS_CMP  = 4'h3;
   localparam logic [3:0] CS_PIN0 = 4'h4;
   localparam logic [3:0] CS_PIN4 = 4'h5;
   localparam logic [3:0] CS_LRC  = 4'h6;
   localparam logic [3:0] CS_ALT  = 4'h7;

   // output route codes
   localparam logic [1:0] OR_PIN3 = 2'h1;
   localparam logic [1:0] OR_PIN4 = 2'h2;

   // pwm resolution masks and reset values
   localparam logic [7:0] MASK6 = 8'h3f;
   localparam logic [7:0] MASK7 = 8'h7f;
   localparam logic [7:0] MASK8 = 8'hff;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_BOUND = 8'hff;

endpackage

// file: rtl/tpc_divider.sv
`timescale 1ns/1ns
// prescaler (1/4/16/64) followed by scaler (s+1)
module tpc_divider
   import tpc_pkg::*;
(
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       tick_i,      // selected source edge
   input  wire logic [1:0] pre_sel_i,   // prescale code
   input  wire logic [4:0] scale_i,     // scaler value
   output logic            count_tick_o // timer_counting_clock pulse
);
   import tpc_pkg::*;

   typedef struct packed {
      logic [5:0] pre_cnt;  // prescale counter
      logic [4:0] scl_cnt;  // scaler counter
   } tpc_div_s;

   tpc_div_s q;
   tpc_div_s d;
   logic     pre_done;     // prescaler terminal
   logic     scl_done;     // scaler terminal

   // terminal count of the prescaler for a code
   function automatic logic [5:0] pre_last(input logic [1:0] sel);
      case (sel)
         2'h0:    pre_last = 6'h00;
         2'h1:    pre_last = 6'h03;
         2'h2:    pre_last = 6'h0f;
         default: pre_last = 6'h3f;
      endcase
   endfunction

   // next state: both stages advance only on source ticks
   always_comb
   begin
      d = q;
      pre_done = (q.pre_cnt >= pre_last(pre_sel_i));
      scl_done = (q.scl_cnt >= scale_i);
      if (tick_i)
      begin
         if (pre_done)
         begin
            d.pre_cnt = 6'h00;
            d.scl_cnt = scl_done ? 5'h00 : q.scl_cnt + 5'h01;
         end
         else
         begin
            d.pre_cnt = q.pre_cnt + 6'h01;
         end
      end
   end

   assign count_tick_o = tick_i & pre_done & scl_done;

   // state register
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         q <= '0;
      else
         q <= d;
   end
endmodule

// file: rtl/tpc_comp.sv
`timescale 1ns/1ns
// comparator result: synchronise, invert, optionally sample
module tpc_comp
   import tpc_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic raw_i,        // analog comparator output, async
   input  wire logic invert_i,     // polarity inversion
   input  wire logic sample_i,     // use held value
   input  wire logic count_tick_i, // timer_counting_clock pulse
   output logic      result_o,     // final result
   output logic      rise_o        // result went 0 to 1
);
   import tpc_pkg::*;

   typedef struct packed {
      logic s1;    // first sync stage
      logic s2;    // second sync stage
      logic held;  // sampled result
      logic last;  // previous result, edge detect
   } tpc_cmp_s;

   tpc_cmp_s q;
   tpc_cmp_s d;
   logic     live;  // inverted, synchronised result

   // next state
   always_comb
   begin
      d = q;
      d.s1 = raw_i;
      d.s2 = q.s1;
      live = q.s2 ^ invert_i;
      if (count_tick_i)
         d.held = live;
      result_o = sample_i ? q.held : live;
      rise_o = result_o & ~q.last;
      d.last = result_o;
   end

   // state register
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         q <= '0;
      else
         q <= d;
   end
endmodule

// file: rtl/tpc_timer_top.sv
`timescale 1ns/1ns
module tpc_timer_top
   import tpc_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // clock source inputs, all asynchronous
   input  wire logic        high_speed_rc_osc_i,
   input  wire logic        low_speed_rc_osc_i,
   input  wire logic        alt_low_speed_rc_osc_i,
   input  wire logic        port_pin_0_i,
   input  wire logic        port_pin_4_i,
   // emulator halt, from core logic on this clock
   input  wire logic        in_circuit_emulator_halt_i,
   // analog comparator raw output, asynchronous
   input  wire logic        cmp_raw_i,
   // analog selects
   output logic             cmp_enable_o,
   output logic [2:0]       cmp_neg_sel_o,
   output logic             cmp_pos_sel_o,
   output logic [1:0]       ladder_span_o,
   output logic [3:0]       ladder_level_o,
   // pins, enable low while driving
   output logic             port_pin_0_o,
   output logic             port_pin_0_oe_n_o,
   output logic             port_pin_3_o,
   output logic             port_pin_3_oe_n_o,
   output logic             port_pin_4_o,
   output logic             port_pin_4_oe_n_o,
   // event requests toward the core
   output logic             timer_irq_o,
   output logic             cmp_irq_o
);
   import tpc_pkg::*;

   // whole module state in one record
   // one record: one reset, one update
   typedef struct packed {
      logic [7:0]  cmp_ctrl;     // comparator_control
      logic [7:0]  cmp_ref;      // comparator_reference_select
      logic [7:0]  tmr_ctrl;     // timer_control
      logic [7:0]  tmr_scale;    // timer_scaling
      logic [7:0]  tmr_bound;    // upper bound
      logic [1:0]  option;       // gating and 7-bit options
      logic [7:0]  count;        // timer_count_value
      logic        tgl;          // period mode toggle
      logic        pwm;          // pwm compare level
      logic        pin0;         // port_pin_0 level
      logic        pin0_oe_n;    // port_pin_0 enable
      logic        pin3;         // port_pin_3 level
      logic        pin3_oe_n;    // port_pin_3 enable
      logic        pin4;         // port_pin_4 level
      logic        pin4_oe_n;    // port_pin_4 enable
      logic        tirq;         // timer request pulse
      logic        cirq;         // comparator request pulse
      logic [31:0] prdata;       // read data
      logic        pready;       // answer strobe
      logic        pslverr;      // unmapped address
      logic [4:0]  sync1;        // first sync stage
      logic [4:0]  sync2;        // second sync stage
      logic [4:0]  sync3;        // edge detect history
   } tpc_top_s;

   tpc_top_s   q;
   tpc_top_s   d;
   logic [4:0] src_edge;     // rising edges of synced sources
   logic       raw_tick;     // edge of the selected source
   logic       src_tick;     // after the halt gate
   logic       count_tick;   // timer_counting_clock pulse
   logic       cmp_result;   // comparator result after polarity
   logic       cmp_rise;     // comparator 0 to 1
   logic       access;       // apb access cycle being answered
   logic [7:0] mask;         // pwm resolution mask
   logic       wave;         // timer waveform before routing
   logic [7:0] wbyte;        // written byte

   // address decode, used by the error path only
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= OFS_STATUS);
   endfunction

   // read mux; unused option and status bits read zero
   // status packs result and waveform
   function automatic logic [7:0] rd_byte(input tpc_top_s s,
                                          input logic [7:0] a,
                                          input logic res,
                                          input logic wv);
      case (a)
         OFS_CMP_CTRL:  rd_byte = {s.cmp_ctrl[7], res, s.cmp_ctrl[5:0]};
         OFS_CMP_REF:   rd_byte = s.cmp_ref;
         OFS_TMR_CTRL:  rd_byte = s.tmr_ctrl;
         OFS_TMR_SCALE: rd_byte = s.tmr_scale;
         OFS_TMR_COUNT: rd_byte = s.count;
         OFS_TMR_BOUND: rd_byte = s.tmr_bound;
         OFS_OPTION:    rd_byte = {6'h00, s.option};
         OFS_STATUS:    rd_byte = {6'h00, wv, res};
         default:       rd_byte = 8'h00;
      endcase
   endfunction

   // divider chain: prescaler then scaler
   // smaller scale ends a running count
   tpc_divider u_div (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .tick_i       (src_tick),
      .pre_sel_i    (q.tmr_scale[TS_PRE_LO +: 2]),
      .scale_i      (q.tmr_scale[TS_SCL_LO +: 5]),
      .count_tick_o (count_tick)
   );

   // comparator polarity, sampling and edge detect
   tpc_comp u_comp (
      .core_clk_i   (core_clk_i),
      .rst_n_i      (rst_n_i),
      .raw_i        (cmp_raw_i),
      .invert_i     (q.cmp_ctrl[CC_INV]),
      .sample_i     (q.cmp_ctrl[CC_SAMPLE]),
      .count_tick_i (count_tick),
      .result_o     (cmp_result),
      .rise_o       (cmp_rise)
   );

   // source selection; sys clock ticks every cycle
   // sys clock is ours: no sync needed
   always_comb
   begin
      src_edge = q.sync2 & ~q.sync3;
      case (q.tmr_ctrl[TC_CLK_LO +: 4])
         CS_SYS:  raw_tick = 1'b1;
         CS_HRC:  raw_tick = src_edge[0];
         CS_LRC:  raw_tick = src_edge[1];
         CS_ALT:  raw_tick = src_edge[2];
         CS_PIN0: raw_tick = src_edge[3];
         CS_PIN4: raw_tick = src_edge[4];
         CS_CMP:  raw_tick = cmp_rise;
         default: raw_tick = 1'b0; // other codes stop the timer
      endcase
      // halt freezes the timer except on the free rc source
      src_tick = raw_tick & (~in_circuit_emulator_halt_i
                 | (q.tmr_ctrl[TC_CLK_LO +: 4] == CS_HRC));
   end

   // main next-state logic
   always_comb
   begin
      d = q;
      wbyte = pwdata_i[7:0];
      access = psel_i & penable_i & ~q.pready;

      // two-stage synchronisers; third stage only for edges
      // edges for all five async sources, fast rc included
      d.sync1 = {port_pin_4_i, port_pin_0_i, alt_low_speed_rc_osc_i,
                 low_speed_rc_osc_i, high_speed_rc_osc_i};
      d.sync2 = q.sync1;
      d.sync3 = q.sync2;

      // resolution: 8-bit, or 6/7-bit by option
      if (!q.tmr_scale[TS_RES6])
      begin
         mask = MASK8;
      end
      else if (q.option[OP_RES7])
      begin
         mask = MASK7;
      end
      else
      begin
         mask = MASK6;
      end

      // counter advances on each counting clock pulse
      // pulse request, cleared by default
      d.tirq = 1'b0;
      if (count_tick)
      begin
         if (!q.tmr_ctrl[TC_MODE])
         begin
            // period mode: wrap at bound, toggle gives half duty
            if (q.count == q.tmr_bound)
            begin
               d.count = 8'h00;
               d.tgl = ~q.tgl;
               d.tirq = 1'b1;
            end
            else
            begin
               d.count = q.count + 8'h01;
            end
         end
         else
         begin
            // pwm mode: free run over the resolution
            if ((q.count & mask) == mask)
            begin
               d.count = 8'h00;
            end
            else
            begin
               d.count = q.count + 8'h01;
            end
         end
      end

      // pwm high while count is within bound; bound = mask is 100%
      // old count, so the pin lags by two
      d.pwm = (q.count & mask) <= (q.tmr_bound & mask);

      // waveform; comparator may gate pwm only
      if (q.tmr_ctrl[TC_MODE])
      begin
         wave = q.pwm & ~(q.option[OP_GATE] & cmp_result);
      end
      else
      begin
         wave = q.tgl;
      end
      // invert applies in both modes
      wave = wave ^ q.tmr_ctrl[TC_INV];

      // output routing to one pin or none
      // unrouted pins are released, low
      d.pin3 = (q.tmr_ctrl[TC_OUT_LO +: 2] == OR_PIN3) & wave;
      d.pin3_oe_n = (q.tmr_ctrl[TC_OUT_LO +: 2] != OR_PIN3);
      d.pin4 = (q.tmr_ctrl[TC_OUT_LO +: 2] == OR_PIN4) & wave;
      d.pin4_oe_n = (q.tmr_ctrl[TC_OUT_LO +: 2] != OR_PIN4);

      // comparator result straight to port_pin_0 when enabled
      // result is already synchronised
      d.pin0 = q.cmp_ref[RS_OUT] & q.cmp_ctrl[CC_EN] & cmp_result;
      d.pin0_oe_n = ~q.cmp_ref[RS_OUT];

      // comparator request on each rising result
      // no request while disabled
      d.cirq = q.cmp_ctrl[CC_EN] & cmp_rise;

      // apb: answer one cycle into the access phase
      // write and read share one answer
      d.pready = access;
      d.pslverr = access & ~mapped(paddr_i);
      if (access && !pwrite_i)
      begin
         d.prdata = {24'h000000,
                     rd_byte(q, paddr_i, cmp_result, wave)};
      end
      else if (access)
      begin
         d.prdata = 32'h00000000;
      end

      // register writes; software count load beats the tick
      // stored result bit reads live
      if (access && pwrite_i)
      begin
         case (paddr_i)
            OFS_CMP_CTRL:  d.cmp_ctrl = wbyte;
            OFS_CMP_REF:   d.cmp_ref = wbyte;
            OFS_TMR_CTRL:  d.tmr_ctrl = wbyte;
            OFS_TMR_SCALE: d.tmr_scale = wbyte;
            OFS_TMR_COUNT: d.count = wbyte;
            OFS_TMR_BOUND: d.tmr_bound = wbyte;
            OFS_OPTION:    d.option = wbyte[1:0];
            default:       d.option = q.option; // read-only or unmapped
         endcase
      end
   end

   // state register; all fields reset to constants
   // pins leave reset released
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.tmr_bound <= RST_BOUND;
         q.cmp_ctrl <= RST_REG;
         q.pin0_oe_n <= 1'b1;
         q.pin3_oe_n <= 1'b1;
         q.pin4_oe_n <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // outputs straight from flip-flops
   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;
   // analog selects from register fields
   assign cmp_enable_o = q.cmp_ctrl[CC_EN];
   assign cmp_neg_sel_o = q.cmp_ctrl[CC_NEG_LO +: 3];
   assign cmp_pos_sel_o = q.cmp_ctrl[CC_POS];
   assign ladder_span_o = q.cmp_ref[RS_SPAN_LO +: 2];
   assign ladder_level_o = q.cmp_ref[RS_LVL_LO +: 4];
   // pins
   assign port_pin_0_o = q.pin0;
   assign port_pin_0_oe_n_o = q.pin0_oe_n;
   assign port_pin_3_o = q.pin3;
   assign port_pin_3_oe_n_o = q.pin3_oe_n;
   assign port_pin_4_o = q.pin4;
   assign port_pin_4_oe_n_o = q.pin4_oe_n;
   // requests
   assign timer_irq_o = q.tirq;
   assign cmp_irq_o = q.cirq;

   // note: async sources are edge-sampled at 10 MHz, so any source
   // faster than half the core clock aliases; the sync chain adds
   // three cycles of latency before a source edge reaches the counter
endmodule

// file: test/tpc_timer_top_asserts.sv
`timescale 1ns/1ns
// watches the apb port, analog selects, pins and requests
module tpc_timer_top_asserts
   import tpc_pkg::*;
(
   input wire logic        core_clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        cmp_enable_o,
   input wire logic [2:0]  cmp_neg_sel_o,
   input wire logic        cmp_pos_sel_o,
   input wire logic [1:0]  ladder_span_o,
   input wire logic [3:0]  ladder_level_o,
   input wire logic        port_pin_0_oe_n_o,
   input wire logic        port_pin_3_oe_n_o,
   input wire logic        port_pin_4_oe_n_o,
   input wire logic        timer_irq_o,
   input wire logic        cmp_irq_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   logic       wr_done;   // write taken at this edge
   logic [7:0] ctl_q;     // shadow of timer_control
   logic       pin0_en_q; // shadow of the pin 0 enable

   // a write lands on the edge that sees pready
   assign wr_done = psel_i & penable_i & pready_o & pwrite_i;

   // shadows follow writes, so the pin checks need no deep $past
   always_ff @(posedge core_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ctl_q     <= 8'h00;
         pin0_en_q <= 1'b0;
      end
      else if (wr_done && paddr_i == OFS_TMR_CTRL)
         ctl_q     <= pwdata_i[7:0];
      else if (wr_done && paddr_i == OFS_CMP_REF)
         pin0_en_q <= pwdata_i[RS_OUT];
   end

   AST_APB_ANSWER : assert property (
      psel_i && penable_i && !pready_o |=> pready_o)
      else $error("access not answered after one wait");
   AST_APB_PULSE : assert property (
      pready_o |=> !pready_o)
      else $error("ready longer than one cycle");
   AST_UPPER_ZERO : assert property (
      pready_o |-> prdata_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   AST_SLVERR : assert property (
      pready_o |-> pslverr_o == (paddr_i > 8'h1c || paddr_i[1:0] != 2'h0))
      else $error("error flag wrong for address");
   AST_NEG_POS : assert property (
      wr_done && paddr_i == OFS_CMP_CTRL |=>
         cmp_neg_sel_o == $past(pwdata_i[3:1])
         && cmp_pos_sel_o == $past(pwdata_i[0]))
      else $error("input selects differ from write");
   AST_LADDER : assert property (
      wr_done && paddr_i == OFS_CMP_REF |=>
         ladder_span_o == $past(pwdata_i[5:4])
         && ladder_level_o == $past(pwdata_i[3:0]))
      else $error("ladder selects differ from write");
   AST_PIN0_EN : assert property (
      wr_done && paddr_i == OFS_CMP_REF |-> ##2
         port_pin_0_oe_n_o == !pin0_en_q)
      else $error("pin 0 enable wrong");
   AST_ROUTE : assert property (
      wr_done && paddr_i == OFS_TMR_CTRL |-> ##2
         port_pin_3_oe_n_o == (ctl_q[3:2] != OR_PIN3)
         && port_pin_4_oe_n_o == (ctl_q[3:2] != OR_PIN4))
      else $error("output route wrong");
   AST_ONE_PIN : assert property (
      port_pin_3_oe_n_o || port_pin_4_oe_n_o)
      else $error("both timer pins driven");
   AST_CMP_IRQ : assert property (
      cmp_irq_o |-> cmp_enable_o || $past(cmp_enable_o))
      else $error("comparator request while disabled");
   AST_TIRQ_MODE : assert property (
      timer_irq_o |-> !ctl_q[TC_MODE] || !$past(ctl_q[TC_MODE]))
      else $error("timer request in pwm mode");
endmodule

bind tpc_timer_top tpc_timer_top_asserts u_asserts (.*);

// file: test/testbench.sv
`timescale 1ns/1ns
module testbench;
   import tpc_pkg::*;
   logic        core_clk_i, rst_n_i, psel_i, penable_i, pwrite_i;
   logic        high_speed_rc_osc_i, low_speed_rc_osc_i;
   logic        alt_low_speed_rc_osc_i, port_pin_0_i, port_pin_4_i;
   logic        in_circuit_emulator_halt_i, cmp_raw_i;
   logic [7:0]  paddr_i, v, m;
   logic [31:0] pwdata_i, prdata_o, rd;
   logic        pready_o, pslverr_o, cmp_enable_o, cmp_pos_sel_o, err;
   logic [2:0]  cmp_neg_sel_o;
   logic [1:0]  ladder_span_o;
   logic [3:0]  ladder_level_o;
   logic        port_pin_0_o, port_pin_0_oe_n_o, port_pin_3_o;
   logic        port_pin_3_oe_n_o, port_pin_4_o, port_pin_4_oe_n_o;
   logic        timer_irq_o, cmp_irq_o, cmp_lvl, cmp_osc;
   int          err_count, comparisons, seed, cyc, i, k, s, g, h, q, n, cq;
   // write masks: result bit read only, invert and clock kept off
   logic [7:0]  msk [6] = '{8'haf, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
   // source codes in order of rising half periods 2..7
   logic [3:0]  src [6] = '{CS_HRC, CS_LRC, CS_ALT,
                            CS_PIN0, CS_PIN4, CS_CMP};

   tpc_timer_top DUT (.*);

   // 10 MHz core clock
   initial
   begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // each source runs at its own rate, so gaps tell them apart
   always @(posedge core_clk_i)
   begin
      cyc                    <= cyc + 1;
      cq                     <= cq + int'(cmp_irq_o === 1'b1);
      high_speed_rc_osc_i    <= (cyc / 2) % 2 != 0;
      low_speed_rc_osc_i     <= (cyc / 3) % 2 != 0;
      alt_low_speed_rc_osc_i <= (cyc / 4) % 2 != 0;
      port_pin_0_i           <= (cyc / 5) % 2 != 0;
      port_pin_4_i           <= (cyc / 6) % 2 != 0;
      cmp_raw_i              <= cmp_osc ? ((cyc / 7) % 2 != 0) : cmp_lvl;
   end

   // cycles between wraps for bound, prescale code, scaler
   function automatic int exp_gap(input int kb, input int p, input int sc);
      return (kb + 1) * (1 << (2 * p)) * (sc + 1);
   endfunction

   // high cycles in one pwm period
   function automatic int pwm_hi(input int kb, input logic [7:0] mk);
      return (kb & int'(mk)) + 1;
   endfunction

   task automatic print_verdict(input int extra);
      err_count += extra;
      if (err_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] e, x);
      comparisons++;
      if (x !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, x);
      end
   endtask

   // one apb transfer; setup starts one edge after the call
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [7:0] wd);
      @(posedge core_clk_i);
      psel_i    <= 1'b1;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= {24'h0, wd};
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      if (n >= 20)
         print_verdict(1);
      rd  = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask

   // timer pin high cycles and timer requests over len cycles
   task automatic count(input int len, output int hi, output int rq);
      hi = 0;
      rq = 0;
      repeat (len)
      begin
         @(posedge core_clk_i);
         hi += int'((port_pin_3_o ^ port_pin_4_o) === 1'b1);
         rq += int'(timer_irq_o === 1'b1);
      end
   endtask

   // cycles between two requests; the first gap may be partial
   task automatic gap(output int gg);
      for (int j = 0; j < 2; j++)
      begin
         gg = 0;
         do
         begin
            @(posedge core_clk_i);
            gg++;
         end
         while (timer_irq_o !== 1'b1 && gg < 20000);
      end
      if (gg >= 20000)
         print_verdict(1);
   endtask

   initial
   begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {high_speed_rc_osc_i, low_speed_rc_osc_i, port_pin_0_i} = '0;
      {alt_low_speed_rc_osc_i, port_pin_4_i, cmp_raw_i} = '0;
      {in_circuit_emulator_halt_i, cmp_lvl, cmp_osc} = '0;
      {err_count, comparisons, cyc, cq} = '0;
      seed = 65;
      rst_n_i = 1'b0;
      repeat (12) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      // whole map after reset, holes answer with an error
      for (i = 0; i < 8; i++)
      begin
         apb(1'b0, 8'(4 * i), 8'h00);
         check("reset value", (i == 5) ? 32'hff : 32'h0, rd);
      end
      apb(1'b0, 8'h20, 8'h00);
      check("error above map", 32'h1, {31'h0, err});
      apb(1'b1, 8'h02, 8'h5a);
      check("error unaligned", 32'h1, {31'h0, err});
      // random writes read back, timer stopped
      repeat (24)
      begin
         i = $unsigned($random(seed)) % 6;
         v = 8'($random(seed)) & msk[i];
         apb(1'b1, 8'(4 * i), v);
         apb(1'b0, 8'(4 * i), 8'h00);
         check("read back", {24'h0, v}, rd);
      end
      // period mode over every prescale code
      for (i = 0; i < 4; i++)
      begin
         k = $unsigned($random(seed)) % 5 + 1;
         s = $unsigned($random(seed)) % 3;
         apb(1'b1, OFS_TMR_BOUND, 8'(k));
         apb(1'b1, OFS_TMR_SCALE, {1'b0, 2'(i), 5'(s)});
         apb(1'b1, OFS_TMR_COUNT, 8'h00);
         apb(1'b1, OFS_TMR_CTRL, {CS_SYS, OR_PIN3, 2'b00});
         gap(g);
         check("wrap gap", 32'(exp_gap(k, i, s)), 32'(g));
         count(2 * g, h, q);
         check("half duty", 32'(g), 32'(h));
         check("wrap requests", 32'd2, 32'(q));
      end
      // every source code but sys, bound 1, comparator toggling
      apb(1'b1, OFS_TMR_BOUND, 8'h01);
      apb(1'b1, OFS_TMR_SCALE, 8'h00);
      apb(1'b1, OFS_CMP_CTRL, 8'h80);
      cmp_osc <= 1'b1;
      for (i = 0; i < 6; i++)
      begin
         apb(1'b1, OFS_TMR_CTRL, {src[i], 4'h4});
         gap(g);
         check("source gap", 32'(4 * (i + 2)), 32'(g));
      end
      n = cq;
      count(140, h, q);
      check("cmp requests", 32'd10, 32'(cq - n));
      // halted core: fast rc keeps counting, system clock stops
      cmp_osc <= 1'b0;
      in_circuit_emulator_halt_i <= 1'b1;
      apb(1'b1, OFS_TMR_CTRL, {CS_HRC, 4'h4});
      gap(g);
      check("halt rc gap", 32'd8, 32'(g));
      apb(1'b1, OFS_TMR_CTRL, {CS_SYS, 4'h4});
      count(5, h, q);
      count(50, h, q);
      check("halt sys requests", 32'd0, 32'(q));
      in_circuit_emulator_halt_i <= 1'b0;
      // pwm at 6, 7 and 8 bits, full duty as the 8-bit corner
      for (i = 0; i < 3; i++)
      begin
         m = (i == 0) ? MASK6 : (i == 1) ? MASK7 : MASK8;
         k = (i == 2) ? 255 : $unsigned($random(seed)) % 256;
         apb(1'b1, OFS_OPTION, {6'h0, i == 1, 1'b0});
         apb(1'b1, OFS_TMR_SCALE, {i != 2, 7'h0});
         apb(1'b1, OFS_TMR_BOUND, 8'(k));
         apb(1'b1, OFS_TMR_CTRL, {CS_SYS, 4'h6});
         count(2 * (int'(m) + 1), h, q);
         count(int'(m) + 1, h, q);
         check("pwm high", 32'(pwm_hi(k, m)), 32'(h));
      end
      // comparator result of one silences pwm, zero restores it
      apb(1'b1, OFS_OPTION, 8'h01);
      apb(1'b1, OFS_TMR_CTRL, {CS_SYS, 4'ha});
      cmp_lvl <= 1'b1;
      count(20, h, q);
      count(256, h, q);
      check("gated high", 32'd0, 32'(h));
      cmp_lvl <= 1'b0;
      count(20, h, q);
      count(256, h, q);
      check("ungated high", 32'd256, 32'(h));
      // inverted, sampled result on pin 0; held while clock stops
      apb(1'b1, OFS_CMP_CTRL, 8'hb0);
      apb(1'b1, OFS_CMP_REF, 8'h80);
      count(10, h, q);
      check("pin 0 inverted", 32'h1, {31'h0, port_pin_0_o});
      apb(1'b0, OFS_STATUS, 8'h00);
      check("status result", 32'h1, rd & 32'h1);
      apb(1'b1, OFS_TMR_CTRL, 8'h04);
      cmp_lvl <= 1'b1;
      count(20, h, q);
      check("held result", 32'h1, {31'h0, port_pin_0_o});
      apb(1'b1, OFS_TMR_CTRL, {CS_SYS, 4'h4});
      count(10, h, q);
      check("resampled", 32'h0, {31'h0, port_pin_0_o});
      print_verdict(0);
   end
endmodule
